// ### core/sbt_pkg.sv
package sbt_pkg;

   // Instruction register width and the instruction encodings.
   localparam int         SBT_IR_W         = 3;
   localparam logic [2:0] SBT_IR_EXTEST    = 3'h0;
   localparam logic [2:0] SBT_IR_IDCODE    = 3'h1;
   localparam logic [2:0] SBT_IR_SAMPLEZ   = 3'h2;
   localparam logic [2:0] SBT_IR_RSVD_A    = 3'h3;
   localparam logic [2:0] SBT_IR_SAMPLE    = 3'h4;
   localparam logic [2:0] SBT_IR_RSVD_B    = 3'h5;
   localparam logic [2:0] SBT_IR_RSVD_C    = 3'h6;
   localparam logic [2:0] SBT_IR_BYPASS    = 3'h7;

   // Pattern loaded into the instruction shifter in Capture-IR.
   localparam logic [2:0] SBT_IR_CAPTURE   = 3'h1;

   // Scan chain lengths for the two data-width builds.
   localparam int         SBT_BSR_X36      = 72;
   localparam int         SBT_BSR_X18      = 53;

   // Identification word layout.
   localparam int         SBT_ID_W         = 32;
   localparam int         SBT_ID_REV_LSB   = 28;
   localparam int         SBT_ID_DEPTH_LSB = 23;
   localparam int         SBT_ID_WIDTH_LSB = 18;
   localparam int         SBT_ID_DEV_LSB   = 12;
   localparam int         SBT_ID_VEND_LSB  = 1;
   localparam logic       SBT_ID_PRESENT   = 1'h1;
   // Vendor code value is arbitrary.
   localparam logic [10:0] SBT_ID_VENDOR   = 11'h2B5;

   // Reset values.
   localparam logic       SBT_TDO_RST      = 1'h0;
   localparam logic       SBT_HIZ_RST      = 1'h0;

   typedef enum logic [3:0] {
      SBT_TLR, SBT_RTI,
      SBT_SEL_DR, SBT_CAP_DR, SBT_SHIFT_DR, SBT_EXIT1_DR,
      SBT_PAUSE_DR, SBT_EXIT2_DR, SBT_UPD_DR,
      SBT_SEL_IR, SBT_CAP_IR, SBT_SHIFT_IR, SBT_EXIT1_IR,
      SBT_PAUSE_IR, SBT_EXIT2_IR, SBT_UPD_IR
   } sbt_state_e;

endpackage

// ### core/sbt_tap.sv
`timescale 1ns/1ps
`default_nettype none

module sbt_tap #(
   parameter int         BSR_LEN   = sbt_pkg::SBT_BSR_X36,
   // Identification field defaults are arbitrary.
   parameter logic [3:0] ID_REV    = 4'h0,
   parameter logic [4:0] ID_DEPTH  = 5'h0,
   parameter logic [4:0] ID_WIDTH  = 5'h0,
   parameter logic [5:0] ID_DEVICE = 6'h0
) (
   input  wire logic               mclk,
   input  wire logic               resetn,
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   input  wire logic [BSR_LEN-1:0] io_ring,
   output var  logic               tdo,
   output var  logic               tdo_oe,
   output var  logic               mem_out_hiz
);
   import sbt_pkg::*;

   localparam logic [SBT_ID_W-1:0] ID_WORD = {
      ID_REV, ID_DEPTH, ID_WIDTH, ID_DEVICE, SBT_ID_VENDOR, SBT_ID_PRESENT};

   logic                rstn_tck_m_q;
   logic                rstn_tck_q;
   logic [BSR_LEN-1:0]  ring_m_q;
   logic [BSR_LEN-1:0]  ring_q;
   sbt_state_e          state_q;
   sbt_state_e          state_d;
   logic [SBT_IR_W-1:0] ir_q;
   logic [SBT_IR_W-1:0] ir_shift_q;
   logic [BSR_LEN-1:0]  bsr_q;
   logic [SBT_ID_W-1:0] id_q;
   logic                byp_q;
   logic                hiz_src_q;
   logic                hiz_m_q;
   logic                tdo_q;
   logic                tdo_oe_q;
   logic                sel_bsr;
   logic                sel_id;

   // The mclk reset reaches the test clock domain through two stages; the
   // test clock may stand still, so this only acts once it toggles.
   always_ff @(posedge tck) begin
      rstn_tck_m_q <= resetn;
      rstn_tck_q   <= rstn_tck_m_q;
   end

   // contact snapshot
   // Ring contacts are asynchronous to the test clock; capture is only as
   // good as their stability at the test clock edge two edges before Capture-DR.
   always_ff @(posedge tck) begin
      ring_m_q <= io_ring;
      ring_q   <= ring_m_q;
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SBT_TLR:      state_d = tms ? SBT_TLR      : SBT_RTI;
         SBT_RTI:      state_d = tms ? SBT_SEL_DR   : SBT_RTI;
         SBT_SEL_DR:   state_d = tms ? SBT_SEL_IR   : SBT_CAP_DR;
         SBT_CAP_DR:   state_d = tms ? SBT_EXIT1_DR : SBT_SHIFT_DR;
         SBT_SHIFT_DR: state_d = tms ? SBT_EXIT1_DR : SBT_SHIFT_DR;
         SBT_EXIT1_DR: state_d = tms ? SBT_UPD_DR   : SBT_PAUSE_DR;
         SBT_PAUSE_DR: state_d = tms ? SBT_EXIT2_DR : SBT_PAUSE_DR;
         SBT_EXIT2_DR: state_d = tms ? SBT_UPD_DR   : SBT_SHIFT_DR;
         SBT_UPD_DR:   state_d = tms ? SBT_SEL_DR   : SBT_RTI;
         SBT_SEL_IR:   state_d = tms ? SBT_TLR      : SBT_CAP_IR;
         SBT_CAP_IR:   state_d = tms ? SBT_EXIT1_IR : SBT_SHIFT_IR;
         SBT_SHIFT_IR: state_d = tms ? SBT_EXIT1_IR : SBT_SHIFT_IR;
         SBT_EXIT1_IR: state_d = tms ? SBT_UPD_IR   : SBT_PAUSE_IR;
         SBT_PAUSE_IR: state_d = tms ? SBT_EXIT2_IR : SBT_PAUSE_IR;
         SBT_EXIT2_IR: state_d = tms ? SBT_UPD_IR   : SBT_SHIFT_IR;
         SBT_UPD_IR:   state_d = tms ? SBT_SEL_DR   : SBT_RTI;
      endcase
   end

   always_ff @(posedge tck) begin
      if (!rstn_tck_q) begin
         state_q <= SBT_TLR;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge tck) begin
      if (!rstn_tck_q) begin
         ir_shift_q <= SBT_IR_IDCODE;
      end else if (state_q == SBT_CAP_IR) begin
         ir_shift_q <= SBT_IR_CAPTURE;
      end else if (state_q == SBT_SHIFT_IR) begin
         ir_shift_q <= {tdi, ir_shift_q[SBT_IR_W-1:1]};
      end
   end

   // reserved codes are not expected; they fall back to bypass.
   always_ff @(posedge tck) begin
      if (!rstn_tck_q || state_q == SBT_TLR) begin
         ir_q <= SBT_IR_IDCODE;
      end else if (state_q == SBT_UPD_IR) begin
         ir_q <= ir_shift_q;
      end
   end

   always_comb begin
      sel_bsr = (ir_q == SBT_IR_EXTEST) || (ir_q == SBT_IR_SAMPLEZ) ||
                (ir_q == SBT_IR_SAMPLE);
      sel_id  = (ir_q == SBT_IR_IDCODE);
   end

   // The chain has no parallel output towards the memory, so there is
   // nothing to preload and nothing driven into address, data or control.
   always_ff @(posedge tck) begin
      if (!rstn_tck_q) begin
         bsr_q <= '0;
      end else if (sel_bsr && state_q == SBT_CAP_DR) begin
         bsr_q <= ring_q;
      end else if (sel_bsr && state_q == SBT_SHIFT_DR) begin
         bsr_q <= {tdi, bsr_q[BSR_LEN-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (!rstn_tck_q) begin
         id_q <= ID_WORD;
      end else if (sel_id && state_q == SBT_CAP_DR) begin
         id_q <= ID_WORD;
      end else if (sel_id && state_q == SBT_SHIFT_DR) begin
         id_q <= {tdi, id_q[SBT_ID_W-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (!rstn_tck_q) begin
         byp_q <= 1'h0;
      end else if (!sel_bsr && !sel_id && state_q == SBT_CAP_DR) begin
         byp_q <= 1'h0;
      end else if (!sel_bsr && !sel_id && state_q == SBT_SHIFT_DR) begin
         byp_q <= tdi;
      end
   end

   // high-Z request
   // Set on the same edge as the instruction itself, so a host that stops
   // the test clock right after Update-IR still gets its high-Z level, and
   // only a flop crosses into the memory clock.
   always_ff @(posedge tck) begin
      if (!rstn_tck_q || state_q == SBT_TLR) begin
         hiz_src_q <= SBT_HIZ_RST;
      end else if (state_q == SBT_UPD_IR) begin
         hiz_src_q <= (ir_shift_q == SBT_IR_EXTEST) ||
                      (ir_shift_q == SBT_IR_SAMPLEZ);
      end
   end

   always_ff @(negedge tck) begin
      if (!rstn_tck_q) begin
         tdo_q    <= SBT_TDO_RST;
         tdo_oe_q <= 1'h0;
      end else begin
         tdo_oe_q <= (state_q == SBT_SHIFT_IR) ||
                     (state_q == SBT_SHIFT_DR);
         if (state_q == SBT_SHIFT_IR) begin
            tdo_q <= ir_shift_q[0];
         end else if (sel_bsr) begin
            tdo_q <= bsr_q[0];
         end else if (sel_id) begin
            tdo_q <= id_q[0];
         end else begin
            tdo_q <= byp_q;
         end
      end
   end

   // The high-Z level is a slow level, so a plain two-stage synchroniser
   // is enough on the memory clock side.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         hiz_m_q     <= SBT_HIZ_RST;
         mem_out_hiz <= SBT_HIZ_RST;
      end else begin
         hiz_m_q     <= hiz_src_q;
         mem_out_hiz <= hiz_m_q;
      end
   end

   assign tdo    = tdo_q;
   assign tdo_oe = tdo_oe_q;

   a_tlr_five_ones: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      tms [*5] |=> (state_q == SBT_TLR))
      else $error("Five high TMS edges did not reach Test-Logic-Reset.");

   a_ir_preset_id: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_TLR) |=> (ir_q == SBT_IR_IDCODE))
      else $error("Instruction not preset to identify in reset state.");

   a_ir_capture_pat: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_CAP_IR) |=> (ir_shift_q[1:0] == 2'h1))
      else $error("Capture-IR did not load the 01 pattern.");

   a_ir_update_load: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_UPD_IR) |=> (ir_q == $past(ir_shift_q)))
      else $error("Update-IR did not load the shifted instruction.");

   a_ir_hold_else: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q != SBT_UPD_IR && state_q != SBT_TLR)
      |=> $stable(ir_q))
      else $error("Instruction changed outside Update-IR.");

   a_id_capture: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_CAP_DR && ir_q == SBT_IR_IDCODE)
      |=> (id_q == ID_WORD) && id_q[0])
      else $error("Identify word not captured in Capture-DR.");

   a_id_shift_msb: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_SHIFT_DR && ir_q == SBT_IR_IDCODE)
      |=> (id_q[SBT_ID_W-1] == $past(tdi)))
      else $error("Identify shift did not take TDI into the MSB.");

   a_bsr_capture: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_CAP_DR && ir_q == SBT_IR_SAMPLE)
      |=> (bsr_q == $past(ring_q)))
      else $error("Sample did not capture the ring in Capture-DR.");

   a_bsr_update_idle: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_UPD_DR) |=> $stable(bsr_q))
      else $error("Update-DR changed the boundary chain.");

   a_byp_zero: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_CAP_DR && ir_q == SBT_IR_BYPASS) |=> !byp_q)
      else $error("Bypass cell did not capture zero.");

   a_hiz_decode: assert property (
      @(posedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_RTI) |->
      (hiz_src_q == ((ir_q == SBT_IR_EXTEST) || (ir_q == SBT_IR_SAMPLEZ))))
      else $error("High-Z request does not match the instruction.");

   a_tdo_oe_shift: assert property (
      @(negedge tck) disable iff (!rstn_tck_q)
      (state_q == SBT_SHIFT_DR || state_q == SBT_SHIFT_IR)
      |=> tdo_oe_q)
      else $error("TDO not enabled while shifting.");

   a_tdo_oe_idle: assert property (
      @(negedge tck) disable iff (!rstn_tck_q)
      !(state_q == SBT_SHIFT_DR || state_q == SBT_SHIFT_IR)
      |=> !tdo_oe_q)
      else $error("TDO enabled outside a shift state.");

   a_hiz_follow: assert property (
      @(posedge mclk) disable iff (!resetn)
      hiz_src_q [*3] |=> mem_out_hiz)
      else $error("Memory outputs not forced to high-Z.");

   a_hiz_release: assert property (
      @(posedge mclk) disable iff (!resetn)
      !hiz_src_q [*3] |=> !mem_out_hiz)
      else $error("Memory outputs held high-Z without request.");

endmodule

`default_nettype wire

// ### tb/sbt_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none

module sbt_jtag_host (
   output var  logic        tck,
   output var  logic        tms,
   output var  logic        tdi,
   input  wire logic        tdo_line,
   output var  logic        res_valid,
   output var  logic [71:0] res_data
);
   initial begin
      tck       = 1'h0;
      tms       = 1'h1;
      tdi       = 1'h1;
      res_valid = 1'h0;
      res_data  = '0;
   end

   // The clock only runs inside a frame and rests high between frames.
   // one clock step
   task automatic step(input logic m, input logic d, output logic s);
      tms = m;
      tdi = d;
      #6.5 tck = 1'h0;
      #7.5 s = tdo_line;
      tck = 1'h1;
      #1;
   endtask

   // Starts and ends in Run-Test-Idle; the last shift bit leaves on TMS high.
   // IR via Update-IR
   task automatic scan(input logic ir, input int n, input logic [71:0] din);
      logic        s;
      logic [71:0] q;
      q = '0;
      step(1'h1, 1'h1, s);
      if (ir) step(1'h1, 1'h1, s);
      step(1'h0, 1'h1, s);
      step(1'h0, 1'h1, s);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], s);
         q[i] = s;
      end
      step(1'h1, 1'h1, s);
      repeat (3) step(1'h0, 1'h1, s);
      res_data  = q;
      res_valid = 1'h1;
      #1 res_valid = 1'h0;
   endtask
endmodule

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   import sbt_pkg::*;

   localparam int          BSR     = SBT_BSR_X36;
   localparam logic [31:0] ID_WORD = {20'h0, SBT_ID_VENDOR, SBT_ID_PRESENT};

   logic           mclk      = 1'h0;
   logic           resetn    = 1'h0;
   logic [BSR-1:0] io_ring   = '0;
   logic           tck, tms, tdi, tdo, tdo_oe, mem_out_hiz, tdo_line, s;
   logic           res_valid, ring_sel;
   logic [71:0]    res_data, din, cap;
   logic [71:0]    exp_q[$];
   logic [2:0]     code;
   int             len;
   int             miscompares = 0;
   int             compares    = 0;
   int             cycles      = 0;
   int             seed        = 87698;

   always #10 mclk = ~mclk;

   // A released line shows the inverse, so an undriven bit never matches.
   assign tdo_line = tdo_oe ? tdo : ~tdo;

   sbt_tap dut (
      .mclk        (mclk),
      .resetn      (resetn),
      .tck         (tck),
      .tms         (tms),
      .tdi         (tdi),
      .io_ring     (io_ring),
      .tdo         (tdo),
      .tdo_oe      (tdo_oe),
      .mem_out_hiz (mem_out_hiz)
   );

   sbt_jtag_host host (
      .tck       (tck),
      .tms       (tms),
      .tdi       (tdi),
      .tdo_line  (tdo_line),
      .res_valid (res_valid),
      .res_data  (res_data)
   );

   task automatic check(input string nm, input logic [71:0] seen,
                        input logic [71:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (miscompares == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [71:0] dr_out(input int l, input logic [71:0] c,
                                         input logic [71:0] d);
      return (c & ((72'h1 << l) - 72'h1)) | (d << l);
   endfunction

   always @(posedge res_valid) begin
      if (exp_q.size() == 0) begin
         miscompares++;
         $display("Error scan_out expected none seen %h", res_data);
      end else
         check("scan_out", res_data, exp_q.pop_front());
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         $display("Error cycles expected below 4000 seen %0d", cycles);
         end_of_test();
      end
   end

   initial begin
      fork
         repeat (6) host.step(1'h1, 1'h1, s);
         begin
            repeat (3) @(posedge mclk);
            #1 resetn = 1'h1;
         end
      join
      repeat (4) host.step(1'h1, 1'h1, s);
      host.step(1'h0, 1'h1, s);
      din = 72'({$random(seed), $random(seed), $random(seed)});
      exp_q.push_back(dr_out(32, 72'(ID_WORD), din));
      host.scan(1'h0, 72, din);
      // Every implemented code is loaded once.
      for (int k = 0; k < 8; k++) begin
         code = k[2:0];
         if (code inside {SBT_IR_RSVD_A, SBT_IR_RSVD_B, SBT_IR_RSVD_C})
            continue;
         exp_q.push_back(72'(SBT_IR_CAPTURE));
         host.scan(1'h1, 3, 72'(code));
         ring_sel = code inside {SBT_IR_EXTEST, SBT_IR_SAMPLEZ, SBT_IR_SAMPLE};
         len = ring_sel ? BSR : (code == SBT_IR_IDCODE ? 32 : 1);
         // Two passes: the ring must be captured anew, Update-DR is inert.
         repeat (2) begin
            @(posedge mclk);
            // ring is still around capture, so every cell compares
            #1 io_ring = 72'({$random(seed), $random(seed), $random(seed)});
            din = 72'({$random(seed), $random(seed), $random(seed)});
            cap = ring_sel ? io_ring : 72'(code == SBT_IR_IDCODE ? ID_WORD : 0);
            exp_q.push_back(dr_out(len, cap, din));
            host.scan(1'h0, 72, din);
         end
         repeat (5) @(posedge mclk);
         #1;
         check("mem_out_hiz", 72'(mem_out_hiz),
               72'(code == SBT_IR_EXTEST || code == SBT_IR_SAMPLEZ));
         check("tdo_oe", 72'(tdo_oe), 72'h0);
      end
      repeat (5) host.step(1'h1, 1'h1, s);
      host.step(1'h0, 1'h1, s);
      exp_q.push_back(dr_out(32, 72'(ID_WORD), din));
      host.scan(1'h0, 72, din);
      repeat (2) @(posedge mclk);
      check("queue_empty", 72'(exp_q.size()), 72'h0);
      end_of_test();
   end
endmodule

`default_nettype wire
